/* File: logic/motion_event_consts.vh */
// Register offsets, field positions, reset values and timing counts
// Assumes 8-bit register port addressed by 7-bit register address
`ifndef MOTION_EVENT_CONSTS_VH
`define MOTION_EVENT_CONSTS_VH
`define KNOCK_CFG_ADDR     7'h58
`define KNOCK_THS_ADDR     7'h59
`define KNOCK_WIN_ADDR     7'h5A
`define WAKE_THS_ADDR      7'h5B
`define WAKE_SLEEP_ADDR    7'h5C
`define FALL_CFG_ADDR      7'h5D
`define ROUTE1_ADDR        7'h5E
`define REG_RESET          8'h00
// knock_and_interrupt_config
`define CFG_MASTER_EN      7
`define CFG_IDLE_HI        6
`define CFG_IDLE_LO        5
`define CFG_WAKE_FILT      4
`define CFG_KX_EN          3
`define CFG_KY_EN          2
`define CFG_KZ_EN          1
`define CFG_LATCH          0
// knock_orientation_threshold
`define THS_FOUR_DIR       7
`define THS_ANGLE_HI       6
`define THS_ANGLE_LO       5
`define THS_KNOCK_HI       4
`define THS_KNOCK_LO       0
// knock_timing_windows
`define WIN_GAP_HI         7
`define WIN_GAP_LO         4
`define WIN_QUIET_HI       3
`define WIN_QUIET_LO       2
`define WIN_SHOCK_HI       1
`define WIN_SHOCK_LO       0
// wake_threshold_reg
`define WTH_DOUBLE_EN      7
`define WTH_HI             5
`define WTH_LO             0
// wake_sleep_durations
`define WDUR_FALL_MSB      7
`define WDUR_HOLD_HI       6
`define WDUR_HOLD_LO       5
`define WDUR_TS_RES        4
`define WDUR_SLEEP_HI      3
`define WDUR_SLEEP_LO      0
// fall_detect_config
`define FALL_LEN_HI        7
`define FALL_LEN_LO        3
`define FALL_THS_HI        2
`define FALL_THS_LO        0
// line_one_event_routing
`define RT_IDLE            7
`define RT_SINGLE          6
`define RT_WAKE            5
`define RT_FALL            4
`define RT_DOUBLE          3
`define RT_ORIENT          2
`define RT_TILT            1
`define RT_TIMER           0
// Window lengths in sample periods
`define GAP_ZERO_SP        16
`define GAP_LSB_SP         32
`define QUIET_ZERO_SP      2
`define QUIET_LSB_SP       4
`define SHOCK_ZERO_SP      4
`define SHOCK_LSB_SP       8
`define SLEEP_ZERO_SP      16
`define SLEEP_LSB_SP       512
// Idle policy codes
`define IDLE_OFF           2'h0
`define IDLE_GYRO_KEEP     2'h1
`define IDLE_GYRO_SLEEP    2'h2
`define IDLE_GYRO_DOWN     2'h3
// Timestamp LSB in ns
`define TS_SLOW_NS         6400000
`define TS_FAST_NS         25000
`define CLK_PERIOD_NS      8
// Decoded values of all-zero fields
`define ORIENT_RESET_DEG   80
`define FALL_RESET_MG      156
`endif

/* File: logic/route_latch.v */
// Routing, gating and optional latching of one event onto line one
// Assumes event pulses synchronous to I_REF_CLK; clear is a one-cycle pulse
module route_latch (
  input  wire i_clk,
  input  wire i_rstn,
  input  wire i_event,
  input  wire i_route,
  input  wire i_gate,
  input  wire i_latch,
  input  wire i_clear,
  output reg  o_req
);
  wire hit = i_event & i_route & i_gate;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_req <= 1'b0;
    end else if (hit) begin
      // Set wins over a coincident clear
      o_req <= 1'b1;
    end else if (!i_latch || i_clear) begin
      o_req <= 1'b0;
    end
  end
endmodule // route_latch

/* File: logic/motion_event_config.v */
// Configuration registers for embedded motion events and line-one routing
// Assumes a synchronous 8-bit register port driven by the host interface
// and detector event pulses synchronous to I_REF_CLK.
`include "motion_event_consts.vh"

// How it works
// RL1: master enable gates the basic events
// RL2: idle policy sets accel and gyro power
// RL3: wake filter bit picks slope or high-pass
// RL4: per-axis knock enables, reset zero
// RL5: latch mode holds requests until read
// RL6: four-direction mode suppresses Z orientation
// RL7: angle code decodes to 80/70/60/50 degrees
// RL8: five-bit knock threshold, reset zero
// RL9: double knock gap 16 or 32n periods
// RL10: quiet time 2 or 4n periods
// RL11: knock max width 4 or 8n periods
// RL12: double knock enable selects double recognition
// RL13: six-bit wake threshold, reset zero
// RL14: fall duration split across two registers
// RL15: two-bit wakeup hold, one period LSB
// RL16: timestamp LSB 6.4 ms or 25 us
// RL17: sleep delay 16 or 512n periods
// RL18: fall threshold code decodes to milli-g
// RL19: routing bits steer events onto line one
// RL20: timer end-of-count routed by its bit
// RL21: line one ORs routed enabled requests
module motion_event_config (
  input  wire        I_REF_CLK,
  input  wire        I_RSTN,
  input  wire        I_WR_EN,
  input  wire        I_RD_EN,
  input  wire [6:0]  I_ADDR,
  input  wire [7:0]  I_WDATA,
  input  wire        I_SRC_READ,
  input  wire        I_EV_IDLE,
  input  wire        I_EV_SINGLE,
  input  wire        I_EV_WAKE,
  input  wire        I_EV_FALL,
  input  wire        I_EV_DOUBLE,
  input  wire        I_EV_ORIENT,
  input  wire        I_EV_TILT,
  input  wire        I_EV_TIMER,
  output reg  [7:0]  O_RDATA,
  output reg         O_IRQ_LINE_ONE,
  output reg  [1:0]  O_ACCEL_LOW_POWER,
  output reg  [1:0]  O_GYRO_IDLE_MODE,
  output reg         O_WAKE_FILTER_HPF,
  output reg  [2:0]  O_KNOCK_AXIS_EN,
  output reg         O_ORIENT_Z_EN,
  output reg  [6:0]  O_ORIENT_ANGLE_DEG,
  output reg  [4:0]  O_KNOCK_THRESHOLD,
  output reg  [8:0]  O_GAP_PERIODS,
  output reg  [3:0]  O_QUIET_PERIODS,
  output reg  [4:0]  O_SHOCK_PERIODS,
  output reg         O_DOUBLE_KNOCK_EN,
  output reg  [5:0]  O_WAKE_THRESHOLD,
  output reg  [5:0]  O_FALL_DURATION,
  output reg  [1:0]  O_WAKE_HOLD,
  output reg  [25:0] O_TS_LSB_NS,
  output reg  [12:0] O_SLEEP_PERIODS,
  output reg  [8:0]  O_FALL_THRESHOLD_MG
);
  reg  [7:0] knock_and_interrupt_config;
  reg  [7:0] knock_orientation_threshold;
  reg  [7:0] knock_timing_windows;
  reg  [7:0] wake_threshold_reg;
  reg  [7:0] wake_sleep_durations;
  reg  [7:0] fall_detect_config;
  reg  [7:0] line_one_event_routing;
  reg  [7:0] next_rdata;
  reg  [6:0] next_angle;
  reg  [8:0] next_fall_mg;
  wire [7:0] ev;
  wire [7:0] gate;
  wire [7:0] req;
  wire       latch_mode;
  wire [1:0] idle_power_policy;
  wire [3:0] gap;
  wire [1:0] quiet;
  wire [1:0] shock;
  wire [3:0] sleep_d;

  // Register writes; reserved bit 6 of wake threshold stays zero
  always @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      knock_and_interrupt_config  <= `REG_RESET;
      knock_orientation_threshold <= `REG_RESET;
      knock_timing_windows        <= `REG_RESET;
      wake_threshold_reg          <= `REG_RESET;
      wake_sleep_durations        <= `REG_RESET;
      fall_detect_config          <= `REG_RESET;
      line_one_event_routing      <= `REG_RESET;
    end else if (I_WR_EN) begin
      if (I_ADDR == `KNOCK_CFG_ADDR) begin
        knock_and_interrupt_config <= I_WDATA;
      end else if (I_ADDR == `KNOCK_THS_ADDR) begin
        knock_orientation_threshold <= I_WDATA;
      end else if (I_ADDR == `KNOCK_WIN_ADDR) begin
        knock_timing_windows <= I_WDATA;
      end else if (I_ADDR == `WAKE_THS_ADDR) begin
        wake_threshold_reg <= I_WDATA & 8'hBF;
      end else if (I_ADDR == `WAKE_SLEEP_ADDR) begin
        wake_sleep_durations <= I_WDATA;
      end else if (I_ADDR == `FALL_CFG_ADDR) begin
        fall_detect_config <= I_WDATA;
      end else if (I_ADDR == `ROUTE1_ADDR) begin
        line_one_event_routing <= I_WDATA;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_rdata = 8'h00;
    if (I_ADDR == `KNOCK_CFG_ADDR) begin
      next_rdata = knock_and_interrupt_config;
    end else if (I_ADDR == `KNOCK_THS_ADDR) begin
      next_rdata = knock_orientation_threshold;
    end else if (I_ADDR == `KNOCK_WIN_ADDR) begin
      next_rdata = knock_timing_windows;
    end else if (I_ADDR == `WAKE_THS_ADDR) begin
      next_rdata = wake_threshold_reg;
    end else if (I_ADDR == `WAKE_SLEEP_ADDR) begin
      next_rdata = wake_sleep_durations;
    end else if (I_ADDR == `FALL_CFG_ADDR) begin
      next_rdata = fall_detect_config;
    end else if (I_ADDR == `ROUTE1_ADDR) begin
      next_rdata = line_one_event_routing;
    end
  end

  assign latch_mode        = knock_and_interrupt_config[`CFG_LATCH];
  assign idle_power_policy = knock_and_interrupt_config[`CFG_IDLE_HI:`CFG_IDLE_LO];
  assign gap     = knock_timing_windows[`WIN_GAP_HI:`WIN_GAP_LO];
  assign quiet   = knock_timing_windows[`WIN_QUIET_HI:`WIN_QUIET_LO];
  assign shock   = knock_timing_windows[`WIN_SHOCK_HI:`WIN_SHOCK_LO];
  assign sleep_d = wake_sleep_durations[`WDUR_SLEEP_HI:`WDUR_SLEEP_LO];

  // RL7: angle threshold decode
  always @* begin
    case (knock_orientation_threshold[`THS_ANGLE_HI:`THS_ANGLE_LO])
      2'h0:    next_angle = 7'd80;
      2'h1:    next_angle = 7'd70;
      2'h2:    next_angle = 7'd60;
      default: next_angle = 7'd50;
    endcase
  end

  // RL18: fall threshold decode
  always @* begin
    case (fall_detect_config[`FALL_THS_HI:`FALL_THS_LO])
      3'h0:    next_fall_mg = 9'd156;
      3'h1:    next_fall_mg = 9'd219;
      3'h2:    next_fall_mg = 9'd250;
      3'h3:    next_fall_mg = 9'd312;
      3'h4:    next_fall_mg = 9'd344;
      3'h5:    next_fall_mg = 9'd406;
      3'h6:    next_fall_mg = 9'd469;
      default: next_fall_mg = 9'd500;
    endcase
  end

  // Event order matches routing bits 7..0
  assign ev = {I_EV_IDLE, I_EV_SINGLE, I_EV_WAKE, I_EV_FALL,
               I_EV_DOUBLE, I_EV_ORIENT, I_EV_TILT, I_EV_TIMER};
  // RL1: master enable gates basic events; tilt and timer pass
  // RL12: double knock only when enabled
  // RL2: idle event needs a nonzero policy
  assign gate = {knock_and_interrupt_config[`CFG_MASTER_EN] &&
                   (idle_power_policy != `IDLE_OFF),
                 {4{knock_and_interrupt_config[`CFG_MASTER_EN]}} &
                   {3'h7, wake_threshold_reg[`WTH_DOUBLE_EN]},
                 knock_and_interrupt_config[`CFG_MASTER_EN],
                 2'h3};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_route
      // RL19: per-event routing; RL20 on bit 0; RL5: latch mode
      route_latch u_route (
        .i_clk   (I_REF_CLK),
        .i_rstn  (I_RSTN),
        .i_event (ev[g]),
        .i_route (line_one_event_routing[g]),
        .i_gate  (gate[g]),
        .i_latch (latch_mode),
        .i_clear (I_SRC_READ),
        .o_req   (req[g])
      );
    end
  endgenerate

  always @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RDATA             <= 8'h00;
      O_IRQ_LINE_ONE      <= 1'b0;
      O_ACCEL_LOW_POWER   <= 2'h0;
      O_GYRO_IDLE_MODE    <= 2'h0;
      O_WAKE_FILTER_HPF   <= 1'b0;
      O_KNOCK_AXIS_EN     <= 3'h0;
      O_ORIENT_Z_EN       <= 1'b1;
      O_ORIENT_ANGLE_DEG  <= 7'd`ORIENT_RESET_DEG;
      O_KNOCK_THRESHOLD   <= 5'h00;
      O_GAP_PERIODS       <= 9'd`GAP_ZERO_SP;
      O_QUIET_PERIODS     <= 4'd`QUIET_ZERO_SP;
      O_SHOCK_PERIODS     <= 5'd`SHOCK_ZERO_SP;
      O_DOUBLE_KNOCK_EN   <= 1'b0;
      O_WAKE_THRESHOLD    <= 6'h00;
      O_FALL_DURATION     <= 6'h00;
      O_WAKE_HOLD         <= 2'h0;
      O_TS_LSB_NS         <= 26'd`TS_SLOW_NS;
      O_SLEEP_PERIODS     <= 13'd`SLEEP_ZERO_SP;
      O_FALL_THRESHOLD_MG <= 9'd`FALL_RESET_MG;
    end else begin
      if (I_RD_EN) begin
        O_RDATA <= next_rdata;
      end
      // RL21: OR of routed requests
      O_IRQ_LINE_ONE <= |req;
      // RL2: bit 0 = accel at low-power rate, gyro mode = policy code
      O_ACCEL_LOW_POWER <= {1'b0, idle_power_policy != `IDLE_OFF};
      O_GYRO_IDLE_MODE  <= idle_power_policy;
      // RL3: filter select
      O_WAKE_FILTER_HPF <= knock_and_interrupt_config[`CFG_WAKE_FILT];
      // RL4: knock axes X,Y,Z
      O_KNOCK_AXIS_EN <= knock_and_interrupt_config[`CFG_KX_EN:`CFG_KZ_EN];
      // RL6: four-direction mode disables Z
      O_ORIENT_Z_EN <= ~knock_orientation_threshold[`THS_FOUR_DIR];
      O_ORIENT_ANGLE_DEG <= next_angle;
      // RL8: knock threshold
      O_KNOCK_THRESHOLD <= knock_orientation_threshold[`THS_KNOCK_HI:`THS_KNOCK_LO];
      // RL9: gap window
      O_GAP_PERIODS <= (gap == 4'h0) ? 9'd`GAP_ZERO_SP : {gap, 5'h00};
      // RL10: quiet window
      O_QUIET_PERIODS <= (quiet == 2'h0) ? 4'd`QUIET_ZERO_SP : {quiet, 2'h0};
      // RL11: shock width
      O_SHOCK_PERIODS <= (shock == 2'h0) ? 5'd`SHOCK_ZERO_SP : {shock, 3'h0};
      O_DOUBLE_KNOCK_EN <= wake_threshold_reg[`WTH_DOUBLE_EN];
      // RL13: wake threshold
      O_WAKE_THRESHOLD <= wake_threshold_reg[`WTH_HI:`WTH_LO];
      // RL14: fall duration assembled
      O_FALL_DURATION <= {wake_sleep_durations[`WDUR_FALL_MSB],
                          fall_detect_config[`FALL_LEN_HI:`FALL_LEN_LO]};
      // RL15: wake hold
      O_WAKE_HOLD <= wake_sleep_durations[`WDUR_HOLD_HI:`WDUR_HOLD_LO];
      // RL16: timestamp resolution
      O_TS_LSB_NS <= wake_sleep_durations[`WDUR_TS_RES] ? 26'd`TS_FAST_NS
                                                         : 26'd`TS_SLOW_NS;
      // RL17: sleep delay
      O_SLEEP_PERIODS <= (sleep_d == 4'h0) ? 13'd`SLEEP_ZERO_SP : {sleep_d, 9'h000};
      O_FALL_THRESHOLD_MG <= next_fall_mg;
    end
  end
endmodule // motion_event_config

/* File: verification/motion_event_checker.sv */
// Checker: decoded configuration outputs follow register writes
// Assumes one clock and an async active-low reset on the top ports
module motion_event_checker (
  input wire        I_REF_CLK,
  input wire        I_RSTN,
  input wire        I_WR_EN,
  input wire [6:0]  I_ADDR,
  input wire [7:0]  I_WDATA,
  input wire        O_ORIENT_Z_EN,
  input wire [6:0]  O_ORIENT_ANGLE_DEG,
  input wire [8:0]  O_GAP_PERIODS,
  input wire [3:0]  O_QUIET_PERIODS,
  input wire [4:0]  O_SHOCK_PERIODS,
  input wire [5:0]  O_FALL_DURATION,
  input wire [25:0] O_TS_LSB_NS,
  input wire [12:0] O_SLEEP_PERIODS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  property p_angle;
    I_WR_EN && I_ADDR == 7'h59 |-> ##2
      O_ORIENT_ANGLE_DEG == 7'h50 - 7'h0A * $past(I_WDATA[6:5], 2);
  endproperty
  a_angle: assert property (p_angle) else $error("angle decode wrong");
  property p_zen;
    I_WR_EN && I_ADDR == 7'h59 |-> ##2 O_ORIENT_Z_EN == !$past(I_WDATA[7], 2);
  endproperty
  a_zen: assert property (p_zen) else $error("z enable wrong");
  property p_gap;
    I_WR_EN && I_ADDR == 7'h5A |-> ##2 O_GAP_PERIODS ==
      ($past(I_WDATA[7:4], 2) == 4'h0 ? 9'h010 : 9'h020 * $past(I_WDATA[7:4], 2));
  endproperty
  a_gap: assert property (p_gap) else $error("gap decode wrong");
  property p_quiet;
    I_WR_EN && I_ADDR == 7'h5A |-> ##2 O_QUIET_PERIODS ==
      ($past(I_WDATA[3:2], 2) == 2'h0 ? 4'h2 : 4'h4 * $past(I_WDATA[3:2], 2));
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet decode wrong");
  property p_shock;
    I_WR_EN && I_ADDR == 7'h5A |-> ##2 O_SHOCK_PERIODS ==
      ($past(I_WDATA[1:0], 2) == 2'h0 ? 5'h04 : 5'h08 * $past(I_WDATA[1:0], 2));
  endproperty
  a_shock: assert property (p_shock) else $error("shock decode wrong");
  property p_fdur;
    I_WR_EN && I_ADDR == 7'h5D |-> ##2 O_FALL_DURATION[4:0] == $past(I_WDATA[7:3], 2);
  endproperty
  a_fdur: assert property (p_fdur) else $error("fall duration wrong");
  property p_ts;
    I_WR_EN && I_ADDR == 7'h5C |-> ##2
      O_TS_LSB_NS == ($past(I_WDATA[4], 2) ? 26'h00061A8 : 26'h061A800);
  endproperty
  a_ts: assert property (p_ts) else $error("timestamp lsb wrong");
  property p_sleep;
    I_WR_EN && I_ADDR == 7'h5C |-> ##2 O_SLEEP_PERIODS ==
      ($past(I_WDATA[3:0], 2) == 4'h0 ? 13'h0010 : 13'h0200 * $past(I_WDATA[3:0], 2));
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep decode wrong");
endmodule // motion_event_checker

bind motion_event_config motion_event_checker u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_WR_EN(I_WR_EN), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .O_ORIENT_Z_EN(O_ORIENT_Z_EN), .O_ORIENT_ANGLE_DEG(O_ORIENT_ANGLE_DEG),
  .O_GAP_PERIODS(O_GAP_PERIODS), .O_QUIET_PERIODS(O_QUIET_PERIODS),
  .O_SHOCK_PERIODS(O_SHOCK_PERIODS), .O_FALL_DURATION(O_FALL_DURATION),
  .O_TS_LSB_NS(O_TS_LSB_NS), .O_SLEEP_PERIODS(O_SLEEP_PERIODS));

/* File: verification/event_source.sv */
// Detector-side model: one-cycle event pulses, bit order as the routing register
// Assumes fire() is called from a process synchronised to clk
module event_source (
  input  wire        clk,
  output logic [7:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev = 8'h00;
  task fire(input int k);
    @(posedge clk);
    #1 ev[k] = 1'b1;
    @(posedge clk);
    #1 ev = 8'h00;
  endtask
endmodule // event_source

/* File: verification/motion_event_config_tb_top.sv */
// Testbench: register access, field decodes and line-one event routing
// Assumes event_source and the bound checker are compiled alongside
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module motion_event_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, wr_en, rd_en, src_rd;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [3:0]  n;
  wire  [7:0]  ev, rdata;
  wire         irq, hpf, zen, dbl;
  wire  [1:0]  alp, gim, hold;
  wire  [2:0]  axis;
  wire  [6:0]  ang;
  wire  [4:0]  kth, sho;
  wire  [8:0]  gap, mg;
  wire  [3:0]  qui;
  wire  [5:0]  wth, fdur;
  wire  [25:0] ts;
  wire  [12:0] slp;
  int          bad_count, cmp_count;
  logic [8:0]  mg_tab [8] = '{9'h09C, 9'h0DB, 9'h0FA, 9'h138, 9'h158, 9'h196, 9'h1D5, 9'h1F4};

  event_source src (.clk(clk), .ev(ev));
  motion_event_config uut (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr),
    .I_WDATA(wdata), .I_SRC_READ(src_rd), .I_EV_IDLE(ev[7]), .I_EV_SINGLE(ev[6]),
    .I_EV_WAKE(ev[5]), .I_EV_FALL(ev[4]), .I_EV_DOUBLE(ev[3]), .I_EV_ORIENT(ev[2]),
    .I_EV_TILT(ev[1]), .I_EV_TIMER(ev[0]), .O_RDATA(rdata), .O_IRQ_LINE_ONE(irq),
    .O_ACCEL_LOW_POWER(alp), .O_GYRO_IDLE_MODE(gim), .O_WAKE_FILTER_HPF(hpf),
    .O_KNOCK_AXIS_EN(axis), .O_ORIENT_Z_EN(zen), .O_ORIENT_ANGLE_DEG(ang),
    .O_KNOCK_THRESHOLD(kth), .O_GAP_PERIODS(gap), .O_QUIET_PERIODS(qui),
    .O_SHOCK_PERIODS(sho), .O_DOUBLE_KNOCK_EN(dbl), .O_WAKE_THRESHOLD(wth),
    .O_FALL_DURATION(fdur), .O_WAKE_HOLD(hold), .O_TS_LSB_NS(ts),
    .O_SLEEP_PERIODS(slp), .O_FALL_THRESHOLD_MG(mg));

  task final_report;
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {wr_en, addr, wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 wr_en = 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 {rd_en, addr} = {1'b1, a};
    @(posedge clk);
    #1 rd_en = 0;
    `CHK(rdata, e)
  endtask
  // Fire one event pulse and look at line one when the request shows
  task ev_chk(input int k, input logic e);
    src.fire(k);
    @(posedge clk);
    #1 `CHK(irq, e)
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #50000 bad_count++;
    final_report();
  end
  initial begin
    {rstn, wr_en, rd_en, src_rd, addr, wdata} = '0;
    repeat (10) @(posedge clk);
    #1 rstn = 1;
    for (int a = 'h58; a < 'h5F; a++) rd(a[6:0], 8'h00);
    `CHK({zen, ang, gap, qui, sho}, {1'b1, 7'h50, 9'h010, 4'h2, 5'h04})
    `CHK({slp, ts, mg}, {13'h0010, 26'h061A800, 9'h09C})
    for (int a = 'h57; a < 'h60; a++) wr(a[6:0], 8'hFF);
    for (int a = 'h57; a < 'h60; a++)
      rd(a[6:0], (a == 'h57 || a == 'h5F) ? 8'h00 : (a == 'h5B) ? 8'hBF : 8'hFF);
    for (int i = 0; i < 16; i++) begin
      n = i[3:0];
      wr(7'h58, {n[3], n[1:0], n[0], n[2:0], 1'b0});
      wr(7'h59, {n[0], n[1:0], n, n[0]});
      wr(7'h5A, {n, n[1:0], n[2:1]});
      wr(7'h5B, {n[0], 1'b0, n, n[1:0]});
      wr(7'h5C, {n[2], n[1:0], n[0], n});
      wr(7'h5D, {n, n[0], n[2:0]});
      repeat (2) @(posedge clk);
      #1 `CHK({alp, gim}, {1'b0, n[1:0] != 0, n[1:0]})
      `CHK({hpf, axis}, {n[0], n[2:0]})
      `CHK({zen, ang}, {~n[0], 7'h50 - 7'h0A * n[1:0]})
      `CHK({kth, dbl, wth}, {n, n[0], n[0], n, n[1:0]})
      `CHK(gap, n == 0 ? 9'h010 : 9'h020 * n)
      `CHK(qui, n[1:0] == 0 ? 4'h2 : 4'h4 * n[1:0])
      `CHK(sho, n[2:1] == 0 ? 5'h04 : 5'h08 * n[2:1])
      `CHK({fdur, hold}, {n[2], n, n[0], n[1:0]})
      `CHK(ts, n[0] ? 26'h00061A8 : 26'h061A800)
      `CHK(slp, n == 0 ? 13'h0010 : 13'h0200 * n)
      `CHK(mg, mg_tab[n[2:0]])
    end
    wr(7'h58, 8'hE0);
    wr(7'h5B, 8'h80);
    for (int k = 0; k < 8; k++) begin
      wr(7'h5E, 8'h01 << k);
      ev_chk(k, 1'b1);
      ev_chk((k + 1) % 8, 1'b0);
      `CHK(irq, 1'b0)
    end
    wr(7'h5E, 8'hFF);
    wr(7'h58, 8'h60);
    for (int k = 0; k < 8; k++) ev_chk(k, k < 2);
    wr(7'h58, 8'h80);
    ev_chk(7, 1'b0);
    wr(7'h5B, 8'h00);
    ev_chk(3, 1'b0);
    wr(7'h58, 8'hE1);
    ev_chk(5, 1'b1);
    `CHK(irq, 1'b1)
    @(posedge clk);
    #1 src_rd = 1;
    @(posedge clk);
    #1 src_rd = 0;
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    final_report();
  end
endmodule // motion_event_config_tb_top
